// file: src/ptc_pump_ctrl.v
// ptc_pump_ctrl.v: pump turn-on controller, automatic and manual modes
// assumes power-up drives sys_rst_i; modem bytes arrive already deframed
// Operation
// - auto mode: pump on only when frequency above minimum and delay elapsed.
// - minimum frequency is a fixed constant, about 3500 Hz, above air.
// - a 60 second delay precedes automatic pump turn-on.
// - only the primary conductivity channel feeds the automatic decision.
// - manual mode: host on/off commands over modem channel switch pump.
// - manual mode never starts the pump automatically.
// - pump commands never block sampler traffic sharing the modem channel.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_map.vh"
module ptc_pump_ctrl #(
  parameter MIN_FREQ_HZ  = `PTC_MIN_FREQ_HZ,
  parameter GATE_CYCLES  = `PTC_GATE_CYCLES,
  parameter DELAY_CYCLES = `PTC_DELAY_CYCLES
) (
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  input  wire       cond_pri_i,
  input  wire       cond_sec_i,
  input  wire       manual_fit_i,
  input  wire [7:0] modem_byte_i,
  input  wire       modem_valid_i,
  output reg  [7:0] sampler_byte_o,
  output reg        sampler_valid_o,
  output reg        pump_on_o,
  output reg        delay_done_o
);
  localparam ST_WAIT = 2'h0;
  localparam ST_ARM  = 2'h1;
  localparam ST_RUN  = 2'h2;
  localparam ST_MAN  = 2'h3;

  wire [31:0] freq;
  wire        freq_valid;
  reg  [1:0]  state_reg;
  reg  [39:0] delay_reg;
  reg         fit_reg;
  wire        above = freq_valid && (freq > MIN_FREQ_HZ);

  function is_pump_cmd;
    input [7:0] b;
    begin
      is_pump_cmd = (b == `PTC_CMD_PUMP_ON) || (b == `PTC_CMD_PUMP_OFF);
    end
  endfunction

  // secondary channel deliberately unused
  ptc_freq_meter #(
    .GATE_CYCLES(GATE_CYCLES),
    .CW         (32)
  ) u_meter (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sig_i    (cond_pri_i),
    .freq_o   (freq),
    .valid_o  (freq_valid)
  );

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg       <= ST_WAIT;
      delay_reg       <= 40'h0;
      fit_reg         <= 1'b0;
      pump_on_o       <= 1'b0;
      delay_done_o    <= 1'b0;
      sampler_byte_o  <= 8'h00;
      sampler_valid_o <= 1'b0;
    end else begin
      // all non-pump bytes pass through with one cycle latency
      sampler_valid_o <= modem_valid_i && !is_pump_cmd(modem_byte_i);
      sampler_byte_o  <= modem_byte_i;
      fit_reg         <= manual_fit_i;
      case (state_reg)
        ST_WAIT: begin
          if (fit_reg)
            state_reg <= ST_MAN;
          else if (above)
            state_reg <= ST_ARM;
        end
        ST_ARM: begin
          // timer counts from entry to ST_ARM, so starts only once submerged
          if (delay_reg == DELAY_CYCLES - 1) begin
            delay_done_o <= 1'b1;
            if (above) begin
              pump_on_o <= 1'b1;
              state_reg <= ST_RUN;
            end
          end else begin
            delay_reg <= delay_reg + 40'h1;
          end
        end
        ST_RUN: begin
          pump_on_o <= 1'b1;
        end
        ST_MAN: begin
          if (modem_valid_i && modem_byte_i == `PTC_CMD_PUMP_ON)
            pump_on_o <= 1'b1;
          else if (modem_valid_i && modem_byte_i == `PTC_CMD_PUMP_OFF)
            pump_on_o <= 1'b0;
        end
        default: state_reg <= ST_WAIT;
      endcase
    end
  end
endmodule // ptc_pump_ctrl
`default_nettype wire

// file: src/ptc_map.vh
// ptc_map.vh: constants for the pump turn-on controller
// assumes a 250 MHz system clock; frequency measured over a 1 s gate
`ifndef PTC_MAP_VH
`define PTC_MAP_VH
`define PTC_CLK_HZ        250000000
`define PTC_MIN_FREQ_HZ   3500
`define PTC_DELAY_S       60
`define PTC_GATE_CYCLES   (`PTC_CLK_HZ)
// 60 s at 250 MHz needs more than 32 bits, so the count is a sized literal
`define PTC_DELAY_CYCLES  40'd15000000000
`define PTC_CMD_PUMP_ON   8'h50
`define PTC_CMD_PUMP_OFF  8'h51
`endif

// file: src/ptc_freq_meter.v
// ptc_freq_meter.v: counts rising edges of a synchronised pin over a gate
// assumes sig_i is asynchronous; result updates once per gate
`timescale 1ns/1ps
`default_nettype none
module ptc_freq_meter #(
  parameter GATE_CYCLES = 250000000,
  parameter CW          = 32
) (
  input  wire          clk_sys_i,
  input  wire          sys_rst_i,
  input  wire          sig_i,
  output reg  [CW-1:0] freq_o,
  output reg           valid_o
);
  reg  [2:0]    sync_reg;
  reg           level_reg;
  reg  [CW-1:0] gate_reg;
  reg  [CW-1:0] edge_reg;
  wire          agree = (sync_reg[1] == sync_reg[2]);
  wire          rise  = agree && sync_reg[2] && !level_reg;

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
      gate_reg  <= {CW{1'b0}};
      edge_reg  <= {CW{1'b0}};
      freq_o    <= {CW{1'b0}};
      valid_o   <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], sig_i};
      if (agree)
        level_reg <= sync_reg[2];
      if (gate_reg == GATE_CYCLES - 1) begin
        gate_reg <= {CW{1'b0}};
        freq_o   <= edge_reg + {{(CW-1){1'b0}}, rise};
        edge_reg <= {CW{1'b0}};
        valid_o  <= 1'b1;
      end else begin
        gate_reg <= gate_reg + {{(CW-1){1'b0}}, 1'b1};
        edge_reg <= edge_reg + {{(CW-1){1'b0}}, rise};
      end
    end
  end
endmodule // ptc_freq_meter
`default_nettype wire

// file: sim/ptc_src.sv
// sensor model: square wave, half period in cycles
// assumes 0 means air: line held low
`timescale 1ns/1ps
`default_nettype none
module ptc_src (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] half_i,
  output var  logic       sig_o);
  logic [7:0] n_reg = 8'h00;
  wire        wrap  = n_reg + 8'h01 >= half_i;
  initial sig_o = 1'b0;
  always @(posedge clk_sys_i) begin
    n_reg <= wrap ? 8'h00 : n_reg + 8'h01;
    sig_o <= half_i != 8'h00 && (sig_o ^ wrap);
  end
endmodule // ptc_src
`default_nettype wire

// file: sim/ptc_pump_ctrl_properties.sv
// port checks of ptc_pump_ctrl
// assumes manual_fit_i moves only in reset
`timescale 1ns/1ps
`default_nettype none
`include "ptc_map.vh"
module ptc_props #(parameter GATE_CYCLES = 1, DELAY_CYCLES = 1) (
  input wire logic       clk_sys_i, sys_rst_i, manual_fit_i, modem_valid_i, sampler_valid_o, pump_on_o, delay_done_o,
  input wire logic [7:0] modem_byte_i, sampler_byte_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  int  c_reg;
  wire m   = manual_fit_i;
  wire on  = modem_valid_i && modem_byte_i == `PTC_CMD_PUMP_ON;
  wire off = modem_valid_i && modem_byte_i == `PTC_CMD_PUMP_OFF;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      c_reg <= 0;
    else
      c_reg <= c_reg + 1;
  end
  sequence fwd_s; sampler_valid_o && sampler_byte_o == $past(modem_byte_i); endsequence
  a_auto_cond: assert property (!m && pump_on_o |-> delay_done_o) else $error("no delay");
  a_auto_delay: assert property ($rose(pump_on_o) && !m |-> c_reg >= GATE_CYCLES + DELAY_CYCLES) else $error("early");
  a_auto_hold: assert property (!m && pump_on_o |=> pump_on_o) else $error("dropped");
  a_man_on: assert property (m && on |=> pump_on_o) else $error("on lost");
  a_man_off: assert property (m && off |=> !pump_on_o) else $error("off lost");
  a_man_only: assert property (m && !pump_on_o && !on |=> !pump_on_o) else $error("self start");
  a_byte_fwd: assert property (modem_valid_i && !on && !off |=> fwd_s) else $error("byte lost");
  a_pump_drop: assert property (on || off |=> !sampler_valid_o) else $error("pump byte out");
endmodule // ptc_props
`default_nettype wire

// file: sim/ptc_pump_ctrl_test.sv
// bench for ptc_pump_ctrl with scaled counts
// assumes ptc_map.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "ptc_map.vh"
module ptc_pump_ctrl_test;
  localparam G = 100, D = 500;
  logic       clk_sys_i = 0, sys_rst_i = 1, man = 0, mv = 0, pri, sec, sv, pump, dd;
  logic [7:0] mb = 0, hp = 0, hs = 0, sb;
  int         error_cnt = 0, samples_checked = 0, k;
  ptc_src u_p (.clk_sys_i, .half_i(hp), .sig_o(pri));
  ptc_src u_s (.clk_sys_i, .half_i(hs), .sig_o(sec));
  ptc_pump_ctrl #(.MIN_FREQ_HZ(3), .GATE_CYCLES(G), .DELAY_CYCLES(D)) u_dut (.clk_sys_i, .sys_rst_i,
    .cond_pri_i(pri), .cond_sec_i(sec), .manual_fit_i(man), .modem_byte_i(mb), .modem_valid_i(mv),
    .sampler_byte_o(sb), .sampler_valid_o(sv), .pump_on_o(pump), .delay_done_o(dd));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin error_cnt++; $display("MISMATCH %0t got %h want %h", $time, g, e); end
  endtask
  task cyc(input int n); repeat (n) @(posedge clk_sys_i); #1; endtask
  task rst(input logic m); sys_rst_i = 1; man = m; cyc(12); sys_rst_i = 0; endtask
  task send(input logic [7:0] b); mb = b; mv = 1; cyc(1); endtask
  task t_auto; // primary exactly at threshold, secondary far above
    rst(0); hp = 17; hs = 2; cyc(3 * (G + D)); chk(pump, 0);
    hs = 0; hp = 10; k = 0;
    while (pump !== 1 && k < 3 * (G + D)) begin cyc(1); k++; end
    chk(k >= D && pump, 1);
    if (pump !== 1) give_verdict;
    chk(dd, 1);
    hp = 0; cyc(3 * G); chk(pump, 1);
    rst(0); hp = 10; cyc(D); chk(pump, 0);
  endtask
  task t_man;
    rst(1); cyc(3 * (G + D)); chk(pump, 0);
    send(`PTC_CMD_PUMP_ON); chk(pump, 1);
    send(8'h3c); chk(sb, 8'h3c);
    chk(sv, 1);
    send(`PTC_CMD_PUMP_OFF); chk(pump, 0);
    chk(sv, 0);
    mv = 0;
  endtask
  initial begin t_auto; t_man; give_verdict; end
endmodule // ptc_pump_ctrl_test
bind ptc_pump_ctrl ptc_props #(.GATE_CYCLES(GATE_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)) u_chk (.clk_sys_i, .sys_rst_i,
  .manual_fit_i, .modem_valid_i, .sampler_valid_o, .pump_on_o, .delay_done_o, .modem_byte_i, .sampler_byte_o);
`default_nettype wire
